// [src/rcw_pkg.sv]
// shared constants and carrier types of the processor-bound packet ring writer
// assumes a single core clock of 40 MHz and a 32-bit classic wishbone register port
package rcw_pkg;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int FRAME_TIME_NS = 125000;
  localparam int FRAME_CYCLES = (FRAME_TIME_NS * 1000) / CLK_PERIOD_PS;

  localparam int NUM_BUF = 4;
  localparam int NUM_CH = 8;
  localparam int PTR_W = 16;
  localparam int LEN_W = 16;
  localparam int LVL_W = 23;
  localparam int TS_W = 16;
  localparam int FRAC_BITS = 6;
  localparam logic [3:0] SIZE_CODE_MAX = 4'h8;

  // register byte offsets
  localparam logic [9:0] OFS_STATUS = 10'h000;
  localparam logic [9:0] OFS_MASK = 10'h004;
  localparam logic [9:0] OFS_FRAME = 10'h008;
  localparam logic [9:0] OFS_BUF_BASE = 10'h100;
  localparam logic [9:0] OFS_CH_BASE = 10'h200;
  localparam logic [9:0] OFS_REGION_MASK = 10'h300;
  localparam logic [1:0] SUB_CFG = 2'h0;
  localparam logic [1:0] SUB_WPTR = 2'h1;
  localparam logic [1:0] SUB_RPTR = 2'h2;
  localparam logic [1:0] SUB_OCC = 2'h3;
  localparam logic [1:0] SUB_LIMIT = 2'h1;
  localparam logic [1:0] SUB_RATE = 2'h2;
  localparam logic [1:0] SUB_LEVEL = 2'h3;

  // field positions
  localparam int BUF_SIZE_LSB = 0;
  localparam int BUF_BASE_LSB = 8;
  localparam int CH_EN_BIT = 0;
  localparam int CH_BUF_LSB = 4;
  localparam int ST_HALF_LSB = 0;
  localparam int ST_LOST_BIT = 4;
  localparam int ST_POLICE_BIT = 5;
  localparam int ST_W = 6;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [ST_W-1:0] RST_MASK = 6'h00;

  typedef struct packed {
    logic [2:0] ch;
    logic [LEN_W-1:0] len;
  } rcw_pkt_type;

  typedef struct packed {
    logic packet_dropped_no_room_flag;
    logic policing_discard_flag;
    logic [1:0] buf_sel;
    logic [2:0] ch;
    logic [PTR_W-1:0] offset;
    logic [LEN_W-1:0] len;
    logic [TS_W-1:0] stamp;
  } rcw_report_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [LEN_W-1:0] len;
  } rcw_store_type;

  typedef enum logic [1:0] {
    RCW_IDLE = 2'b01,
    RCW_EVAL = 2'b10
  } rcw_state_type;

endpackage

// [src/rcw_bucket.sv]
// token bucket arithmetic for one packet of one channel
// assumes the caller holds the bucket state and applies the returned level
`timescale 1ns/1ps
module rcw_bucket
  import rcw_pkg::*;
(
  input wire logic [LVL_W-1:0] level_in,
  input wire logic primed,
  input wire logic [TS_W-1:0] last_stamp,
  input wire logic [TS_W-1:0] now_stamp,
  input wire logic [15:0] rate,
  input wire logic [15:0] limit,
  input wire logic [LEN_W-1:0] len,
  output logic pass,
  output logic [LVL_W-1:0] level_out,
  output logic [LVL_W-1:0] level_drained
);
  wire [TS_W-1:0] elapsed = now_stamp - last_stamp;
  wire [31:0] drain = elapsed * rate;
  wire [31:0] level_wide = {{(32 - LVL_W){1'b0}}, level_in};
  // drain what has leaked since the last packet, never below empty
  wire [LVL_W-1:0] drained = !primed ? '0 :
                             (drain >= level_wide) ? '0 : LVL_W'(level_wide - drain);
  // zero limit field stands for the largest bucket
  wire [LVL_W-1:0] limit_units = (limit == 16'h0000) ?
                                 LVL_W'(32'h0001_0000 << FRAC_BITS) :
                                 LVL_W'({16'h0000, limit} << FRAC_BITS);
  wire [LVL_W-1:0] add_units = LVL_W'({16'h0000, len} << FRAC_BITS);
  wire [LVL_W:0] sum = {1'b0, drained} + {1'b0, add_units};

  assign pass = sum <= {1'b0, limit_units};
  assign level_out = pass ? sum[LVL_W-1:0] : drained;
  assign level_drained = drained;
endmodule

// [src/rcw_ring_writer.sv]
// processor-bound packet ring writer: policing, ring placement, reports, irq
// assumes packets arrive from same-clock disassembly logic and a wishbone master
`timescale 1ns/1ps

module rcw_ring_writer
  import rcw_pkg::*;
#(
  parameter int FRAME_COUNT_CYCLES = FRAME_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pkt_valid,
  input wire rcw_pkt_type pkt_in,
  output logic pkt_ready,
  output logic store_valid,
  output rcw_store_type store_out,
  output logic report_valid,
  output rcw_report_type report_out,
  output logic irq
);

  function automatic logic [PTR_W-1:0] ring_mask(input logic [3:0] code);
    logic [3:0] c;
    c = (code > SIZE_CODE_MAX) ? SIZE_CODE_MAX : code;
    ring_mask = PTR_W'((32'h0000_0100 << c) - 32'h1);
  endfunction

  function automatic logic [PTR_W-1:0] occupancy(input logic [PTR_W-1:0] wp,
                                                 input logic [PTR_W-1:0] rp,
                                                 input logic [PTR_W-1:0] m);
    occupancy = (wp - rp) & m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // register state
  logic [31:0] buf_cfg [NUM_BUF];
  logic [PTR_W-1:0] buf_wptr [NUM_BUF];
  logic [PTR_W-1:0] buf_rptr [NUM_BUF];
  logic [31:0] ch_cfg [NUM_CH];
  logic [15:0] ch_limit [NUM_CH];
  logic [15:0] ch_rate [NUM_CH];
  logic [LVL_W-1:0] current_bucket_level [NUM_CH];
  logic [TS_W-1:0] ch_last [NUM_CH];
  logic [NUM_CH-1:0] ch_primed;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [31:0] frame_div;
  logic [TS_W-1:0] frame_count;
  rcw_state_type state;
  rcw_pkt_type pkt;

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire [9:0] region = wb_adr_i & OFS_REGION_MASK;
  wire [1:0] sub = wb_adr_i[3:2];
  wire [1:0] buf_idx = wb_adr_i[5:4];
  wire [2:0] ch_idx = wb_adr_i[6:4];
  wire hit_buf = (region == OFS_BUF_BASE) && (wb_adr_i[7:6] == 2'b00);
  wire hit_ch = (region == OFS_CH_BASE) && !wb_adr_i[7];
  wire wr_status = bus_wr && (wb_adr_i == OFS_STATUS);
  wire wr_mask = bus_wr && (wb_adr_i == OFS_MASK);
  wire wr_buf = bus_wr && hit_buf;
  wire wr_ch = bus_wr && hit_ch;

  // per-ring occupancy and half-full level
  logic [PTR_W-1:0] occ [NUM_BUF];
  logic [NUM_BUF-1:0] half_full;
  for (genvar b = 0; b < NUM_BUF; b++) begin : g_ring
    wire [PTR_W-1:0] m = ring_mask(buf_cfg[b][BUF_SIZE_LSB +: 4]);
    assign occ[b] = occupancy(buf_wptr[b], buf_rptr[b], m);
    assign half_full[b] = {1'b0, occ[b]} > ({2'b00, m[PTR_W-1:1]} + 17'h1);
  end

  // packet evaluation
  wire [1:0] sel_buf = ch_cfg[pkt.ch][CH_BUF_LSB +: 2];
  wire ch_enabled = ch_cfg[pkt.ch][CH_EN_BIT];
  wire [PTR_W-1:0] sel_mask = ring_mask(buf_cfg[sel_buf][BUF_SIZE_LSB +: 4]);
  wire [PTR_W-1:0] sel_wp = buf_wptr[sel_buf];
  // one byte is kept free so that equal pointers always mean empty
  wire [PTR_W-1:0] sel_free = sel_mask - occ[sel_buf];
  wire fits = pkt.len <= sel_free;
  wire police_pass;
  wire [LVL_W-1:0] level_after;
  rcw_bucket u_bucket (
    .level_in(current_bucket_level[pkt.ch]),
    .primed(ch_primed[pkt.ch]),
    .last_stamp(ch_last[pkt.ch]),
    .now_stamp(frame_count),
    .rate(ch_rate[pkt.ch]),
    .limit(ch_limit[pkt.ch]),
    .len(pkt.len),
    .pass(police_pass),
    .level_out(level_after),
    .level_drained()
  );

  wire evaluating = (state == RCW_EVAL) && ch_enabled;
  wire police_drop = evaluating && !police_pass;
  wire room_drop = evaluating && police_pass && !fits;
  wire do_store = evaluating && police_pass && fits;
  wire [PTR_W-1:0] next_wp = (sel_wp + pkt.len) & sel_mask;
  wire [31:0] base_addr = {buf_cfg[sel_buf][31:BUF_BASE_LSB], {BUF_BASE_LSB{1'b0}}};

  wire [ST_W-1:0] events = {police_drop, room_drop, half_full};
  wire [ST_W-1:0] clr_bits = wr_status ? wb_dat_i[ST_W-1:0] : '0;
  // a new event wins over a simultaneous clear
  wire [ST_W-1:0] next_status = (status & ~clr_bits) | events;

  // read data selection
  logic [31:0] rd_buf;
  logic [31:0] rd_ch;
  always_comb begin
    case (sub)
      SUB_CFG: rd_buf = buf_cfg[buf_idx];
      SUB_WPTR: rd_buf = {16'h0000, buf_wptr[buf_idx]};
      SUB_RPTR: rd_buf = {16'h0000, buf_rptr[buf_idx]};
      SUB_OCC: rd_buf = {16'h0000, occ[buf_idx]};
      default: rd_buf = RST_WORD;
    endcase
    case (sub)
      SUB_CFG: rd_ch = ch_cfg[ch_idx];
      SUB_LIMIT: rd_ch = {16'h0000, ch_limit[ch_idx]};
      SUB_RATE: rd_ch = {16'h0000, ch_rate[ch_idx]};
      SUB_LEVEL: rd_ch = {{(32 - LVL_W){1'b0}}, current_bucket_level[ch_idx]};
      default: rd_ch = RST_WORD;
    endcase
  end
  wire [31:0] next_rdata = (wb_adr_i == OFS_STATUS) ? {26'h0, status} :
                           (wb_adr_i == OFS_MASK) ? {26'h0, mask} :
                           (wb_adr_i == OFS_FRAME) ? {16'h0000, frame_count} :
                           hit_buf ? rd_buf :
                           hit_ch ? rd_ch : RST_WORD;

  // wishbone slave: one wait state, ack for one cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req && !wb_we_i ? next_rdata : RST_WORD;
    end
  end

  // frame time base for bucket leakage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_div <= '0;
      frame_count <= '0;
    end else if (frame_div >= 32'(FRAME_COUNT_CYCLES - 1)) begin
      frame_div <= '0;
      frame_count <= frame_count + 16'h1;
    end else begin
      frame_div <= frame_div + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= '0;
      mask <= RST_MASK;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= ST_W'(merge(32'(mask), wb_dat_i, wb_sel_i));
      end
      irq <= |(next_status & mask);
    end
  end

  // ring tables; software writes take precedence over the hardware pointer update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int b = 0; b < NUM_BUF; b++) begin
        buf_cfg[b] <= RST_WORD;
        buf_wptr[b] <= '0;
        buf_rptr[b] <= '0;
      end
    end else begin
      if (do_store) begin
        buf_wptr[sel_buf] <= next_wp;
      end
      if (wr_buf && sub == SUB_CFG) begin
        buf_cfg[buf_idx] <= merge(buf_cfg[buf_idx], wb_dat_i, wb_sel_i);
      end
      if (wr_buf && sub == SUB_WPTR) begin
        buf_wptr[buf_idx] <= PTR_W'(merge(32'(buf_wptr[buf_idx]), wb_dat_i, wb_sel_i));
      end
      if (wr_buf && sub == SUB_RPTR) begin
        buf_rptr[buf_idx] <= PTR_W'(merge(32'(buf_rptr[buf_idx]), wb_dat_i, wb_sel_i));
      end
    end
  end

  // channel tables
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch_primed <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        ch_cfg[c] <= RST_WORD;
        ch_limit[c] <= '0;
        ch_rate[c] <= '0;
        current_bucket_level[c] <= '0;
        ch_last[c] <= '0;
      end
    end else begin
      if (evaluating) begin
        current_bucket_level[pkt.ch] <= level_after;
        ch_last[pkt.ch] <= frame_count;
        ch_primed[pkt.ch] <= 1'b1;
      end
      if (wr_ch && sub == SUB_CFG) begin
        ch_cfg[ch_idx] <= merge(ch_cfg[ch_idx], wb_dat_i, wb_sel_i);
        ch_primed[ch_idx] <= 1'b0;
      end
      if (wr_ch && sub == SUB_LIMIT) begin
        ch_limit[ch_idx] <= 16'(merge(32'(ch_limit[ch_idx]), wb_dat_i, wb_sel_i));
      end
      if (wr_ch && sub == SUB_RATE) begin
        ch_rate[ch_idx] <= 16'(merge(32'(ch_rate[ch_idx]), wb_dat_i, wb_sel_i));
      end
      if (wr_ch && sub == SUB_LEVEL) begin
        current_bucket_level[ch_idx] <= LVL_W'(wb_dat_i);
      end
    end
  end

  // packet sequencer: take one packet, evaluate it the next cycle, then report it if its channel is enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= RCW_IDLE;
      pkt <= '0;
      pkt_ready <= 1'b0;
      store_valid <= 1'b0;
      store_out <= '0;
      report_valid <= 1'b0;
      report_out <= '0;
    end else begin
      store_valid <= 1'b0;
      report_valid <= 1'b0;
      case (state)
        RCW_IDLE: begin
          pkt_ready <= 1'b1;
          if (pkt_valid && pkt_ready) begin
            pkt <= pkt_in;
            pkt_ready <= 1'b0;
            state <= RCW_EVAL;
          end
        end
        RCW_EVAL: begin
          store_valid <= do_store;
          store_out.addr <= base_addr + {16'h0000, sel_wp};
          store_out.len <= pkt.len;
          report_valid <= ch_enabled;
          report_out.packet_dropped_no_room_flag <= room_drop;
          report_out.policing_discard_flag <= police_drop;
          report_out.buf_sel <= sel_buf;
          report_out.ch <= pkt.ch;
          report_out.offset <= sel_wp;
          report_out.len <= pkt.len;
          report_out.stamp <= frame_count;
          pkt_ready <= 1'b1;
          state <= RCW_IDLE;
        end
        default: begin
          pkt_ready <= 1'b0;
          state <= RCW_IDLE;
        end
      endcase
    end
  end

endmodule

// [testbench/rcw_ring_writer_props.sv]
// checker for the ring writer ports: bus handshake, packet timing, report fields
// assumes a single core clock and synchronous active-high reset
`timescale 1ns/1ps
module rcw_ring_writer_props
  import rcw_pkg::*;
#(
  parameter int FRAME_COUNT_CYCLES = FRAME_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pkt_valid,
  input wire rcw_pkt_type pkt_in,
  input wire logic pkt_ready,
  input wire logic store_valid,
  input wire rcw_store_type store_out,
  input wire logic report_valid,
  input wire rcw_report_type report_out,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ack_one_cycle_a:
    assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  dat_idle_a:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  ready_gap_a:
    assert property ((pkt_valid && pkt_ready) |=> !pkt_ready ##1 pkt_ready)
      else $error("ready spacing wrong");
  report_cause_a:
    assert property (report_valid |-> $past(pkt_valid && pkt_ready, 2))
      else $error("report without packet");
  report_len_a:
    assert property (report_valid |-> report_out.len == $past(pkt_in.len, 2)
      && report_out.ch == $past(pkt_in.ch, 2)) else $error("report fields wrong");
  store_report_a:
    assert property (store_valid |-> report_valid && !report_out.policing_discard_flag
      && !report_out.packet_dropped_no_room_flag) else $error("store with drop flag");
  store_place_a:
    assert property (store_valid |-> store_out.addr[7:0] == report_out.offset[7:0]
      && store_out.len == report_out.len) else $error("store place wrong");
  flags_excl_a:
    assert property (report_valid |-> !(report_out.policing_discard_flag
      && report_out.packet_dropped_no_room_flag)) else $error("both drop flags");
  report_pulse_a:
    assert property (report_valid |=> !report_valid) else $error("report held");
endmodule

bind rcw_ring_writer rcw_ring_writer_props #(.FRAME_COUNT_CYCLES(FRAME_COUNT_CYCLES)) u_props (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pkt_valid(pkt_valid), .pkt_in(pkt_in),
  .pkt_ready(pkt_ready), .store_valid(store_valid), .store_out(store_out),
  .report_valid(report_valid), .report_out(report_out), .irq(irq));

// [testbench/rcw_host_model.sv]
// host software model: follows each stored packet's report to find its next read pointer
// assumes the bench writes the pointer back over the register bus
`timescale 1ns/1ps
module rcw_host_model
  import rcw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic report_valid,
  input wire rcw_report_type report_out,
  input wire logic [NUM_BUF-1:0][PTR_W-1:0] ring_mask,
  output logic [NUM_BUF-1:0][PTR_W-1:0] host_rp
);
  logic kept;
  assign kept = report_valid && !report_out.packet_dropped_no_room_flag
    && !report_out.policing_discard_flag;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_rp <= '0;
    end else if (kept) begin
      // consume the packet: point past its last byte, wrapped to the ring
      host_rp[report_out.buf_sel] <= (report_out.offset + report_out.len)
        & ring_mask[report_out.buf_sel];
    end
  end
endmodule

// [testbench/test_rcw_ring_writer.sv]
// self-checking bench: packet table through two rings, then register and irq cases
// assumes the host model and checker files compile ahead of this one
`timescale 1ns/1ps
module test_rcw_ring_writer
  import rcw_pkg::*;
;
  typedef struct packed {
    logic [2:0] ch;
    logic [15:0] len;
    logic rep;
    logic st;
    logic [15:0] off;
    logic [1:0] bs;
    logic [1:0] fl;
  } rcw_row_type;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic pkt_valid = 1'h0;
  rcw_pkt_type pkt_in = '0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, pkt_ready, store_valid, report_valid, irq;
  logic [1:0] flags;
  rcw_store_type store_out;
  rcw_report_type report_out;
  logic [NUM_BUF-1:0][PTR_W-1:0] host_rp;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  // edges seen out of reset, to predict the frame stamp of each report
  int live = 0;
  localparam int FRAME_LEN = 10;
  rcw_row_type rows [7];
  assign flags = {report_out.packet_dropped_no_room_flag, report_out.policing_discard_flag};
  always #12.5 core_clk = ~core_clk;
  rcw_ring_writer #(.FRAME_COUNT_CYCLES(FRAME_LEN)) uut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pkt_valid(pkt_valid), .pkt_in(pkt_in),
    .pkt_ready(pkt_ready), .store_valid(store_valid), .store_out(store_out),
    .report_valid(report_valid), .report_out(report_out), .irq(irq));
  rcw_host_model host (.core_clk(core_clk), .rst(rst), .report_valid(report_valid),
    .report_out(report_out), .ring_mask({16'h0, 16'h0, 16'h1FF, 16'hFF}), .host_rp(host_rp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic send(input logic [2:0] c, input logic [15:0] l);
    @(posedge core_clk);
    pkt_valid <= 1'h1;
    pkt_in <= '{ch: c, len: l};
    do
      @(posedge core_clk);
    while (pkt_ready !== 1'h1);
    pkt_valid <= 1'h0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (rst) begin
      live = 0;
    end else begin
      live++;
    end
    if (cycles == 5000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    rows = '{'{3'h0, 16'h64, 1'h1, 1'h1, 16'h0, 2'h0, 2'h0},
      '{3'h1, 16'h12C, 1'h1, 1'h1, 16'h0, 2'h1, 2'h0},
      '{3'h0, 16'h64, 1'h1, 1'h1, 16'h64, 2'h0, 2'h0},
      '{3'h1, 16'hFA, 1'h1, 1'h0, 16'h12C, 2'h1, 2'h2},
      '{3'h3, 16'h2, 1'h1, 1'h0, 16'hC8, 2'h0, 2'h1},
      '{3'h2, 16'h5, 1'h0, 1'h0, 16'h0, 2'h0, 2'h0},
      '{3'h0, 16'h37, 1'h1, 1'h1, 16'hC8, 2'h0, 2'h0}};
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_MASK, 32'h0);
    rd(OFS_BUF_BASE, 32'h0);
    rd(10'h104, 32'h0);
    rd(10'h0F0, 32'h0);
    wb(1'h1, OFS_BUF_BASE, 32'h0001_0000);
    wb(1'h1, 10'h110, 32'h0002_0001);
    wb(1'h1, OFS_CH_BASE, 32'h1);
    wb(1'h1, 10'h210, 32'h11);
    wb(1'h1, 10'h230, 32'h1);
    wb(1'h1, 10'h234, 32'h1);
    foreach (rows[i]) begin
      send(rows[i].ch, rows[i].len);
      chk(report_valid, rows[i].rep);
      chk(store_valid, rows[i].st);
      if (rows[i].rep) begin
        chk(report_out.offset, rows[i].off);
        chk(report_out.len, rows[i].len);
        chk(report_out.buf_sel, rows[i].bs);
        chk(flags, rows[i].fl);
        chk(report_out.ch, rows[i].ch);
        chk(report_out.stamp, 32'((live - 1) / FRAME_LEN));
      end
      if (rows[i].st) chk(store_out.addr, {14'h0, rows[i].bs + 2'h1, rows[i].off});
      $display("row %0d done", i);
    end
    rd(10'h20C, 32'h3FC0);
    rd(OFS_STATUS, 32'h33);
    chk(irq, 1'h0);
    wb(1'h1, OFS_MASK, 32'h10);
    @(posedge core_clk);
    #1;
    chk(irq, 1'h1);
    wb(1'h1, OFS_STATUS, 32'h10);
    @(posedge core_clk);
    #1;
    chk(irq, 1'h0);
    wb(1'h1, OFS_MASK, 32'h1);
    @(posedge core_clk);
    #1;
    chk(irq, 1'h1);
    rd(10'h10C, 32'hFF);
    wb(1'h1, 10'h108, {16'h0, host_rp[0]});
    send(3'h0, 16'hA);
    chk(store_out.addr, 32'h0001_00FF);
    rd(10'h104, 32'h9);
    rd(10'h10C, 32'hA);
    wb(1'h1, 10'h108, {16'h0, host_rp[0]});
    rd(10'h10C, 32'h0);
    wb(1'h1, OFS_STATUS, 32'h3F);
    rd(OFS_STATUS, 32'h2);
    wb(1'h1, 10'h104, 32'h0);
    rd(10'h104, 32'h0);
    // full bucket with no leak is policed; a leak over a frame lets the next one through
    wb(1'h1, 10'h20C, 32'h0040_0000);
    send(3'h0, 16'h4);
    chk(flags, 2'h1);
    chk(store_valid, 1'h0);
    wb(1'h1, 10'h208, 32'h100);
    repeat (10) @(posedge core_clk);
    send(3'h0, 16'h4);
    chk(flags, 2'h0);
    chk(store_valid, 1'h1);
    chk(store_out.addr, 32'h0001_0000);
    // reset in mid-run clears tables, flags and outputs
    @(posedge core_clk);
    rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    chk(irq, 1'h0);
    chk(pkt_ready, 1'h0);
    rd(OFS_STATUS, 32'h0);
    rd(10'h110, 32'h0);
    rd(10'h20C, 32'h0);
    $display("register cases done");
    end_sim;
  end
endmodule
